//--- ucpm_top.sv
// Purpose: mode control for a downstream usb charging port
// Assumes: 40 MHz core_clk, synchronous reset, avalon-mm slave for status
// Notes: analog thresholds and current limiting live in the front end
`timescale 1ns/1ps
module ucpm_top
  import ucpm_pkg::*;
#(
  parameter int unsigned SCHEME_1V2_CYCLES = SCHEME_1V2_CYC,
  parameter int unsigned DISCHARGE_CYCLES = DISCHARGE_CYC
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic mode_select_bit1,
  input wire logic mode_select_bit2,
  input wire logic mode_select_bit3,
  input wire logic enable,
  input wire logic overcurrent,
  input wire logic bc12_attach,
  input wire logic line_release,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output ucpm_port_ctl_t port_ctl
);

  logic [2:0] sel_meta_ff, sel_sync_ff, sel_prev_ff;
  logic [1:0] en_meta_ff, oc_meta_ff;
  logic en_ff, oc_ff;
  ucpm_mode_t mode_ff, nxt_mode;
  ucpm_scheme_t scheme_ff;
  logic [31:0] tmr_1v2_ff;
  logic [31:0] dis_cnt_ff;
  logic discharge_ff;
  logic [3:0] ctrl_ff;
  logic ack_ff;
  logic [2:0] sel_now;
  logic sel_change;
  logic quiet_change;
  logic power_on;
  logic data_on;

  function automatic ucpm_mode_t decode_mode(input logic [2:0] s);
    unique case (s)
      3'b000, 3'b001: decode_mode = UCPM_MODE_DCP;
      3'b010, 3'b011: decode_mode = UCPM_MODE_SDP;
      3'b100, 3'b101: decode_mode = UCPM_MODE_CLIENT;
      3'b110: decode_mode = UCPM_MODE_SDP;
      3'b111: decode_mode = UCPM_MODE_CDP;
    endcase
  endfunction : decode_mode

  // pins come from outside the clock domain
  always_ff @(posedge core_clk) begin
    sel_meta_ff <= {mode_select_bit1, mode_select_bit2, mode_select_bit3};
    sel_sync_ff <= sel_meta_ff;
    en_meta_ff <= {en_meta_ff[0], enable};
    oc_meta_ff <= {oc_meta_ff[0], overcurrent};
    en_ff <= en_meta_ff[1];
    oc_ff <= oc_meta_ff[1];
  end

  assign sel_now = sel_sync_ff;
  assign sel_change = sel_now != sel_prev_ff;
  // pairs that share a power path skip the output discharge
  assign quiet_change = (sel_now[2:1] == 2'b00 && sel_prev_ff[2:1] == 2'b00) ||
    (sel_now[2:1] == 2'b11 && sel_prev_ff[2:1] == 2'b11);
  assign nxt_mode = decode_mode(sel_now);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      sel_prev_ff <= 3'h0;
      mode_ff <= UCPM_MODE_DCP;
    end else begin
      sel_prev_ff <= sel_now;
      mode_ff <= nxt_mode;
    end
  end

  // discharge timer on select code changes outside the quiet pairs
  always_ff @(posedge core_clk) begin
    if (reset) begin
      dis_cnt_ff <= 32'h0;
      discharge_ff <= 1'b0;
    end else if (sel_change && !quiet_change) begin
      dis_cnt_ff <= DISCHARGE_CYCLES - 1;
      discharge_ff <= 1'b1;
    end else if (dis_cnt_ff != 32'h0) begin
      dis_cnt_ff <= dis_cnt_ff - 32'h1;
    end else begin
      discharge_ff <= 1'b0;
    end
  end

  // auto-detect scheme machine, only live in dedicated charging
  always_ff @(posedge core_clk) begin
    if (reset) begin
      scheme_ff <= UCPM_SCH_DIV;
      tmr_1v2_ff <= 32'h0;
    end else if (mode_ff != UCPM_MODE_DCP) begin
      scheme_ff <= UCPM_SCH_DIV;
      tmr_1v2_ff <= 32'h0;
    end else begin
      unique case (scheme_ff)
        UCPM_SCH_DIV: begin
          // without an attach event divider equipment keeps this scheme
          if (bc12_attach) begin
            scheme_ff <= UCPM_SCH_1V2;
            tmr_1v2_ff <= SCHEME_1V2_CYCLES - 1;
          end
        end
        UCPM_SCH_1V2: begin
          if (tmr_1v2_ff == 32'h0) begin
            scheme_ff <= UCPM_SCH_SHORT;
          end else begin
            tmr_1v2_ff <= tmr_1v2_ff - 32'h1;
          end
        end
        UCPM_SCH_SHORT: begin
          if (line_release) begin
            scheme_ff <= UCPM_SCH_DIV;
          end
        end
        default: scheme_ff <= UCPM_SCH_DIV;
      endcase
    end
  end

  // power stays on through scheme moves, so attach never discharges
  assign power_on = (mode_ff != UCPM_MODE_CLIENT) && !discharge_ff;
  // current limit is deliberately not a term here
  assign data_on = en_ff && !discharge_ff && (mode_ff != UCPM_MODE_DCP) &&
    !ctrl_ff[0];

  always_ff @(posedge core_clk) begin
    if (reset) begin
      port_ctl <= '0;
      port_ctl.fault_n <= 1'b1;
    end else begin
      port_ctl.power_on <= power_on;
      port_ctl.data_switch_on <= data_on;
      port_ctl.drive_2v7 <= (mode_ff == UCPM_MODE_DCP) && scheme_ff == UCPM_SCH_DIV;
      port_ctl.short_lines <= (mode_ff == UCPM_MODE_DCP) && scheme_ff != UCPM_SCH_DIV;
      port_ctl.pullup_1v2 <= (mode_ff == UCPM_MODE_DCP) && scheme_ff == UCPM_SCH_1V2;
      port_ctl.discharge <= discharge_ff;
      // low-limit dcp code 000 and sdp code 110 hide overcurrent
      port_ctl.fault_n <= !(oc_ff && power_on && sel_now != 3'b000 && sel_now != 3'b110);
      port_ctl.high_limit <= (sel_now == 3'b001) || (sel_now == 3'b111);
    end
  end

  // avalon slave: one wait cycle, answer on the second edge
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ack_ff <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      ack_ff <= (avs_read || avs_write) && !ack_ff && avs_waitrequest;
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest && !ack_ff);
    end
  end

  // write lands only on the edge where the master sees waitrequest low
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_ff <= CTRL_RESET;
    end else if (avs_write && !avs_waitrequest && avs_address == OFS_CTRL) begin
      ctrl_ff <= avs_writedata[3:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      avs_readdata <= 32'h0;
    end else if ((avs_read || avs_write) && avs_waitrequest && !ack_ff) begin
      unique case (avs_address)
        OFS_CTRL: avs_readdata <= {28'h0, ctrl_ff};
        OFS_STAT: avs_readdata <= {17'h0, discharge_ff, scheme_ff, mode_ff, en_ff, sel_now,
          data_on, power_on, oc_ff};
        OFS_ID: avs_readdata <= ID_VALUE;
        default: avs_readdata <= 32'h0;
      endcase
    end
  end

  a_client_power: assert property (@(posedge core_clk) disable iff (reset)
    mode_ff == UCPM_MODE_CLIENT |=> !port_ctl.power_on)
    else $error("power on in client mode");
  a_dcp_data_off: assert property (@(posedge core_clk) disable iff (reset)
    mode_ff == UCPM_MODE_DCP |=> !port_ctl.data_switch_on)
    else $error("data switch on in dcp");
  a_enable_data_off: assert property (@(posedge core_clk) disable iff (reset)
    !en_ff |=> !port_ctl.data_switch_on)
    else $error("data switch on with enable low");
  a_discharge_data_off: assert property (@(posedge core_clk) disable iff (reset)
    discharge_ff |=> !port_ctl.data_switch_on)
    else $error("data switch on during discharge");
  a_quiet_pair: assert property (@(posedge core_clk) disable iff (reset)
    sel_change && quiet_change && !discharge_ff |=> !discharge_ff)
    else $error("discharge on quiet mode change");
  a_scheme_timer: assert property (@(posedge core_clk) disable iff (reset)
    scheme_ff == UCPM_SCH_1V2 && tmr_1v2_ff == 32'h0 && mode_ff == UCPM_MODE_DCP
    |=> scheme_ff == UCPM_SCH_SHORT)
    else $error("1.2 V scheme did not end");
  a_release_div: assert property (@(posedge core_clk) disable iff (reset)
    scheme_ff == UCPM_SCH_SHORT && line_release |=> scheme_ff == UCPM_SCH_DIV)
    else $error("release did not restore divider");
  a_low_fault_mask: assert property (@(posedge core_clk) disable iff (reset)
    sel_now == 3'b000 |=> port_ctl.fault_n)
    else $error("fault asserted in low-limit dcp");
  a_attach_1v2: assert property (@(posedge core_clk) disable iff (reset)
    scheme_ff == UCPM_SCH_DIV && mode_ff == UCPM_MODE_DCP && bc12_attach
    |=> scheme_ff == UCPM_SCH_1V2 ##1 port_ctl.pullup_1v2)
    else $error("attach did not start 1.2 V scheme");
  a_cdp_decode: assert property (@(posedge core_clk) disable iff (reset)
    sel_now == 3'b111 |=> mode_ff == UCPM_MODE_CDP)
    else $error("code 111 did not select cdp");
  a_cdp_quiet: assert property (@(posedge core_clk) disable iff (reset)
    sel_change && sel_now == 3'b111 && sel_prev_ff == 3'b110 && !discharge_ff |=> !discharge_ff)
    else $error("discharge between 110 and 111");
  a_sdp_fault_mask: assert property (@(posedge core_clk) disable iff (reset)
    sel_now == 3'b110 |=> port_ctl.fault_n)
    else $error("fault asserted in low-limit sdp");
  a_short_drive: assert property (@(posedge core_clk) disable iff (reset)
    mode_ff == UCPM_MODE_DCP && scheme_ff == UCPM_SCH_SHORT
    |=> port_ctl.short_lines && !port_ctl.pullup_1v2 && !port_ctl.drive_2v7)
    else $error("shorted scheme outputs wrong");
  a_div_drive: assert property (@(posedge core_clk) disable iff (reset)
    mode_ff == UCPM_MODE_DCP && scheme_ff == UCPM_SCH_DIV
    |=> port_ctl.drive_2v7 && !port_ctl.short_lines)
    else $error("divider scheme outputs wrong");
  a_pullup_drive: assert property (@(posedge core_clk) disable iff (reset)
    mode_ff == UCPM_MODE_DCP && scheme_ff == UCPM_SCH_1V2
    |=> port_ctl.pullup_1v2 && port_ctl.short_lines)
    else $error("1.2 V scheme outputs wrong");
  a_auto_entry: assert property (@(posedge core_clk) disable iff (reset)
    mode_ff != UCPM_MODE_DCP |=> scheme_ff == UCPM_SCH_DIV)
    else $error("scheme not divider outside dcp");
  a_attach_quiet: assert property (@(posedge core_clk) disable iff (reset)
    bc12_attach && !sel_change && !discharge_ff |=> !discharge_ff)
    else $error("attach caused discharge");
  a_short_hold: assert property (@(posedge core_clk) disable iff (reset)
    mode_ff == UCPM_MODE_DCP && scheme_ff == UCPM_SCH_SHORT && !line_release
    |=> scheme_ff == UCPM_SCH_SHORT)
    else $error("shorted scheme left without release");
  a_div_hold: assert property (@(posedge core_clk) disable iff (reset)
    scheme_ff == UCPM_SCH_DIV && !bc12_attach |=> scheme_ff == UCPM_SCH_DIV)
    else $error("divider scheme left without attach");
  a_cdp_data_on: assert property (@(posedge core_clk) disable iff (reset)
    mode_ff == UCPM_MODE_CDP && en_ff && !discharge_ff && !ctrl_ff[0]
    |=> port_ctl.data_switch_on)
    else $error("data switch off in cdp");
  a_limit_data_on: assert property (@(posedge core_clk) disable iff (reset)
    oc_ff && mode_ff != UCPM_MODE_DCP && en_ff && !discharge_ff && !ctrl_ff[0]
    |=> port_ctl.data_switch_on)
    else $error("current limit turned data switch off");
  a_discharge_power: assert property (@(posedge core_clk) disable iff (reset)
    discharge_ff |=> !port_ctl.power_on)
    else $error("power on during discharge");
  a_timer_bound: assert property (@(posedge core_clk) disable iff (reset)
    scheme_ff == UCPM_SCH_1V2 |-> tmr_1v2_ff < SCHEME_1V2_CYCLES)
    else $error("1.2 V timer out of range");
  a_wait_single: assert property (@(posedge core_clk) disable iff (reset)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");

endmodule : ucpm_top

//--- ucpm_pkg.sv
// Purpose: shared constants and types for the charge port mode control block
// Assumes: 40 MHz core clock, synchronous active-high reset
// Notes: register offsets are word aligned byte addresses
package ucpm_pkg;

  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned SCHEME_1V2_US = 100;
  localparam int unsigned SCHEME_1V2_CYC = SCHEME_1V2_US * (CLK_HZ / 1000000);
  localparam int unsigned DISCHARGE_US = 50;
  localparam int unsigned DISCHARGE_CYC = DISCHARGE_US * (CLK_HZ / 1000000);

  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STAT = 4'h4;
  localparam logic [3:0] OFS_ID = 4'h8;
  localparam logic [31:0] ID_VALUE = 32'h0000C0DE;  // arbitrary value
  localparam logic [3:0] CTRL_RESET = 4'h0;

  typedef enum logic [3:0] {
    UCPM_MODE_DCP = 4'b0001,
    UCPM_MODE_SDP = 4'b0010,
    UCPM_MODE_CLIENT = 4'b0100,
    UCPM_MODE_CDP = 4'b1000
  } ucpm_mode_t;

  typedef enum logic [2:0] {
    UCPM_SCH_DIV = 3'b001,
    UCPM_SCH_1V2 = 3'b010,
    UCPM_SCH_SHORT = 3'b100
  } ucpm_scheme_t;

  typedef struct packed {
    logic power_on;
    logic data_switch_on;
    logic drive_2v7;
    logic short_lines;
    logic pullup_1v2;
    logic discharge;
    logic fault_n;
    logic high_limit;
  } ucpm_port_ctl_t;

endpackage : ucpm_pkg

//--- ucpm_partner.sv
// Purpose: portable equipment model on the far side of the data lines
// Assumes: line levels already turned into events by the front end
// Notes: divider-only equipment never raises the bc1.2 attach event
`timescale 1ns/1ps
module ucpm_partner (
  input wire logic core_clk,
  input wire logic plug,
  input wire logic unplug,
  input wire logic bc12_kind,
  output logic bc12_attach,
  output logic line_release
);
  initial begin
    bc12_attach = 1'b0;
    line_release = 1'b0;
  end
  // both detection steps collapse to one attach event here
  always @(posedge core_clk) begin
    bc12_attach <= plug & bc12_kind;
    line_release <= unplug;
  end
endmodule : ucpm_partner

//--- ucpm_top_test.sv
// Purpose: self-checking bench for the charge port mode control block
// Assumes: shortened scheme and discharge counts
// Notes: driver queues expectations, a watcher compares them
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module ucpm_top_test;
  import ucpm_pkg::*;
  localparam int unsigned S1V2 = 8;
  localparam int unsigned DIS = 5;
  logic core_clk, reset, enable, overcurrent, plug, unplug, kind, look;
  logic bc12_attach, line_release, avs_read, avs_write, avs_waitrequest;
  logic [2:0] code;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  ucpm_port_ctl_t port_ctl;
  logic [63:0] q[$];
  int n_fail = 0;
  int n_compared = 0;
  ucpm_top #(.SCHEME_1V2_CYCLES(S1V2), .DISCHARGE_CYCLES(DIS)) ucpm_top_inst (
    .core_clk(core_clk), .reset(reset), .mode_select_bit1(code[2]),
    .mode_select_bit2(code[1]), .mode_select_bit3(code[0]), .enable(enable),
    .overcurrent(overcurrent), .bc12_attach(bc12_attach), .line_release(line_release),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .port_ctl(port_ctl));
  ucpm_partner ucpm_partner_inst (.core_clk(core_clk), .plug(plug), .unplug(unplug),
    .bc12_kind(kind), .bc12_attach(bc12_attach), .line_release(line_release));
  always @(posedge core_clk) begin
    logic [63:0] e;
    if (avs_read && avs_waitrequest === 1'b0) begin
      e = q.pop_front();
      `CHK("readdata", e[31:0], avs_readdata & e[63:32])
    end
    if (look) begin
      e = q.pop_front();
      `CHK("port_ctl", e[7:0], port_ctl & e[39:32])
    end
  end
  task automatic finish_test();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, m);
    int i;
    if (!wr) q.push_back({m, d & m});
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 20);
    if (i >= 20) begin
      n_fail++;
      finish_test();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask : bus
  task automatic see(input logic [7:0] m, v);
    q.push_back({24'h0, m, 24'h0, v & m});
    look <= 1'b1;
    @(posedge core_clk);
    look <= 1'b0;
    @(posedge core_clk);
  endtask : see
  task automatic poke(input logic rel);
    if (rel) unplug <= 1'b1;
    else plug <= 1'b1;
    @(posedge core_clk);
    plug <= 1'b0;
    unplug <= 1'b0;
  endtask : poke
  // port_ctl for a settled code with enable high and the divider scheme
  function automatic logic [7:0] want(input logic [2:0] c, input logic oc);
    logic dcp, cli;
    dcp = c[2:1] == 2'b00;
    cli = c[2:1] == 2'b10;
    return {!cli, !dcp, dcp, 3'b000, !(oc && !cli && c != 3'b000 && c != 3'b110),
      c == 3'b001 || c == 3'b111};
  endfunction : want
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    int k;
    logic oc;
    reset = 1'b1;
    {code, enable, overcurrent, plug, unplug, kind, look} = 9'h22;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    k = $urandom(32'haf51);
    tick(2);
    reset <= 1'b0;
    tick(12);
    see(8'hFF, want(3'b000, 1'b0));
    bus(0, OFS_STAT, 32'h8C0, 32'h7FF8);
    bus(0, OFS_ID, ID_VALUE, '1);
    bus(0, 4'hC, 32'h0, '1);
    bus(1, OFS_CTRL, 32'h1, 32'h0);
    bus(0, OFS_CTRL, 32'h1, 32'h1);
    bus(1, OFS_CTRL, 32'h0, 32'h0);
    for (k = 1; k < 9; k++) begin
      oc = $urandom % 2;
      code <= k[2:0];
      overcurrent <= oc;
      tick(5);
      if (k inside {1, 7}) see(8'h04, 8'h00);
      else if (k inside {2, 4, 6}) see(8'h44, 8'h04);
      tick(DIS + 12);
      see(8'hFF, want(k[2:0], oc));
      if (k == 7) begin
        enable <= 1'b0;
        tick(8);
        see(8'h40, 8'h00);
        enable <= 1'b1;
        tick(8);
      end
    end
    overcurrent <= 1'b0;
    poke(0);
    tick(3);
    see(8'hFC, 8'h98);
    tick(S1V2 + 4);
    see(8'hFC, 8'h90);
    bus(0, OFS_STAT, 32'h2000, 32'h3800);
    poke(0);
    tick(4);
    see(8'hFC, 8'h90);
    poke(1);
    tick(4);
    see(8'hFC, 8'hA0);
    kind <= 1'b0;
    poke(0);
    tick(S1V2 + 4);
    see(8'hFC, 8'hA0);
    finish_test();
  end
endmodule : ucpm_top_test
